// File: verilog/charger_defines.svh
// offsets, field positions, reset values and codes of the charger registers
// Behaviour
// [R1] top input bit enables input high impedance
// [R2] four-bit input voltage limit, default 0110
// [R3] three-bit input current limit code table
// [R4] first variant default from source-select and boost pins
// [R5] second variant default from source detection
// [R6] writing register reset restores all defaults
// [R7] register reset keeps host-controlled mode
// [R8] watchdog restart bit restarts serial watchdog
// [R9] host spaces watchdog restarts 20 us apart
// [R10] bit 5 enables boost output, resets 0
// [R11] boost enable overrides charge enable
// [R12] bit 4 enables charging, resets 1
// [R13] host never sets boost and charge together
// [R14] three-bit minimum system voltage, default 101
// [R15] bit 0 selects boost current limit
// [R16] configuration register resets to 00011011
// [R17] charge current register layout, resets 01100000
// [R18] all fields read back last written value; config bits 7:6 are not stored and read back 0
// [R19] slave answers at seven-bit address 6bh
// [R20] undefined register address gets nack, idle
// [R21] any host write enters host mode
// [R22] reset and watchdog bits self clear
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH
`define CHG_SLAVE_ADDR 7'h6b
`define CHG_NUM_REGS 8'h03
`define CHG_ADDR_SRC 8'h00
`define CHG_ADDR_CFG 8'h01
`define CHG_ADDR_CHG 8'h02
`define CHG_SRC_RESET_HI 5'h06
`define CHG_CFG_RESET 8'h1b
`define CHG_CHG_RESET 8'h60
`define CHG_CFG_STORE_MASK 8'h3f
`define CHG_CFG_REG_RESET 7
`define CHG_CFG_WD_RESTART 6
`define CHG_CFG_BOOST_EN 5
`define CHG_CFG_CHARGE_EN 4
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_100MA 3'h0
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_500MA 3'h2
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_1A 3'h4
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_2A 3'h6
`define CHG_EXTERNAL_CURRENT_LIMIT_PIN_3A 3'h7
`endif

// File: verilog/charger_pkg.sv
// types shared by the charger register bank files
package charger_pkg;
	typedef enum logic [1:0] {
		SRC_SDP,
		SRC_DCP_CDP,
		SRC_DIV12,
		SRC_DIV3
	} source_type_e;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_REG,
		ST_WDATA,
		ST_ACK,
		ST_RDATA,
		ST_MACK,
		ST_IGNORE
	} link_state_e;
	typedef struct packed {
		link_state_e state;
		link_state_e after_ack;
		logic scl_q;
		logic sda_q;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic mack_ok;
		logic sda_oe;
		logic sda_o;
		logic host_mode;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} link_s;
	typedef struct packed {
		logic [7:0] src;
		logic [7:0] cfg;
		logic [7:0] chg;
		logic [7:0] rd_data;
		logic wd_restart;
		logic charge_active;
	} regbank_s;
endpackage

// File: verilog/charger_regs.sv
// register storage, defaults and write side effects of the charger
`include "charger_defines.svh"
module charger_regs #(
	parameter bit SECOND_VARIANT = 1'b0
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	input wire logic source_select,
	input wire logic boost_request,
	input wire charger_pkg::source_type_e source_type,
	output logic [7:0] src,
	output logic [7:0] cfg,
	output logic [7:0] chg,
	output logic [7:0] rd_data,
	output logic wd_restart,
	output logic charge_active
);
	import charger_pkg::*;

	regbank_s bank_ff;
	regbank_s nxt_bank;
	logic [2:0] external_current_limit_pin_dflt;

	always_comb begin
		nxt_bank = bank_ff;
		nxt_bank.wd_restart = 1'b0;
		if (!SECOND_VARIANT) begin
			if (!source_select)
				external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_3A; // R4
			else if (boost_request)
				external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_500MA; // R4
			else
				external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_100MA; // R4
		end else begin
			unique case (source_type)
			SRC_SDP: external_current_limit_pin_dflt = boost_request ? `CHG_EXTERNAL_CURRENT_LIMIT_PIN_500MA :
				`CHG_EXTERNAL_CURRENT_LIMIT_PIN_100MA; // R5
			SRC_DCP_CDP: external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_3A; // R5
			SRC_DIV12: external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_2A; // R5
			SRC_DIV3: external_current_limit_pin_dflt = `CHG_EXTERNAL_CURRENT_LIMIT_PIN_1A; // R5
			endcase
		end
		if (wr_en) begin
			case (wr_addr)
			`CHG_ADDR_SRC: nxt_bank.src = wr_data; // R1 R2 R3 R18
			`CHG_ADDR_CFG: begin
				if (wr_data[`CHG_CFG_REG_RESET]) begin
					// host mode lives in the link logic, so it survives
					nxt_bank.src = {`CHG_SRC_RESET_HI, external_current_limit_pin_dflt}; // R6 R7
					nxt_bank.cfg = `CHG_CFG_RESET; // R6 R16
					nxt_bank.chg = `CHG_CHG_RESET; // R6
				end else begin
					// action bits are never stored, so they read 0
					nxt_bank.cfg = wr_data & `CHG_CFG_STORE_MASK; // R22
					nxt_bank.wd_restart = wr_data[`CHG_CFG_WD_RESTART]; // R8
				end
			end
			`CHG_ADDR_CHG: nxt_bank.chg = wr_data; // R17 R18
			default: begin
			end
			endcase
		end
		if (!rst_b) begin
			nxt_bank.src = {`CHG_SRC_RESET_HI, external_current_limit_pin_dflt}; // R2 R4 R5
			nxt_bank.cfg = `CHG_CFG_RESET; // R16
			nxt_bank.chg = `CHG_CHG_RESET; // R17
			nxt_bank.wd_restart = 1'b0;
		end
		case (rd_addr)
		`CHG_ADDR_SRC: nxt_bank.rd_data = nxt_bank.src; // R18
		`CHG_ADDR_CFG: nxt_bank.rd_data = nxt_bank.cfg; // R18
		`CHG_ADDR_CHG: nxt_bank.rd_data = nxt_bank.chg; // R18
		default: nxt_bank.rd_data = 8'h00;
		endcase
		nxt_bank.charge_active = nxt_bank.cfg[`CHG_CFG_CHARGE_EN] &
			~nxt_bank.cfg[`CHG_CFG_BOOST_EN]; // R11
	end

	always_ff @(posedge clock) begin
		bank_ff <= nxt_bank;
	end

	assign src = bank_ff.src;
	assign cfg = bank_ff.cfg;
	assign chg = bank_ff.chg;
	assign rd_data = bank_ff.rd_data;
	assign wd_restart = bank_ff.wd_restart;
	assign charge_active = bank_ff.charge_active;

	AST_REG_RESET_DEFAULTS: assert property (@(posedge clock) disable iff (!rst_b)
		wr_en && wr_addr == `CHG_ADDR_CFG && wr_data[`CHG_CFG_REG_RESET]
		|=> cfg == `CHG_CFG_RESET && chg == `CHG_CHG_RESET
		&& src[7:3] == `CHG_SRC_RESET_HI) // R6
		else $error("register reset did not restore defaults");
	AST_WD_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
		wr_en && wr_addr == `CHG_ADDR_CFG && wr_data[7:6] == 2'b01
		|=> wd_restart ##1 !wd_restart) // R8
		else $error("watchdog restart not a single pulse");
	AST_ACTION_BITS_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(wd_restart) |-> cfg[7:6] == 2'b00 ##1 cfg[7:6] == 2'b00) // R22
		else $error("action bits read back non-zero");
	AST_BOOST_WINS: assert property (@(posedge clock) disable iff (!rst_b)
		cfg[`CHG_CFG_BOOST_EN] |-> !charge_active) // R11
		else $error("charging active while boost requested");
	// the pointer has already stepped past the written register here
	AST_WRITE_READBACK: assert property (@(posedge clock) disable iff (!rst_b)
		wr_en && wr_addr == `CHG_ADDR_CHG
		|=> chg == $past(wr_data)) // R18
		else $error("charge register readback mismatch");
endmodule

// File: verilog/charger_control_register_bank.sv
// two-wire slave port and top level of the charger control register bank
`include "charger_defines.svh"
module charger_control_register_bank #(
	parameter logic [6:0] SLAVE_ADDR = `CHG_SLAVE_ADDR,
	parameter bit SECOND_VARIANT = 1'b0
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic source_select,
	input wire logic boost_request,
	input wire charger_pkg::source_type_e source_type,
	output logic input_hiz_enable,
	output logic [3:0] input_voltage_limit,
	output logic [2:0] input_current_limit,
	output logic boost_output_enable,
	output logic battery_charge_enable,
	output logic charge_active,
	output logic [2:0] min_system_voltage,
	output logic boost_current_limit,
	output logic [5:0] fast_charge_current,
	output logic boost_cold_select,
	output logic forced_reduced_current,
	output logic host_mode,
	output logic watchdog_restart
);
	import charger_pkg::*;

	// ******************************************************************
	// reset value and state
	// ******************************************************************

	// both lines idle high, so no false start is seen after reset
	localparam link_s LINK_RESET = '{
		state: ST_IDLE,
		after_ack: ST_IDLE,
		scl_q: 1'b1,
		sda_q: 1'b1,
		bit_cnt: 4'h0,
		shift: 8'h00,
		ptr: 8'h00,
		mack_ok: 1'b0,
		sda_oe: 1'b0,
		sda_o: 1'b0,
		host_mode: 1'b0,
		wr_en: 1'b0,
		wr_addr: 8'h00,
		wr_data: 8'h00
	};

	link_s link_ff;
	link_s nxt_link;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] src;
	logic [7:0] cfg;
	logic [7:0] chg;
	logic [7:0] rd_data;

	// ******************************************************************
	// register storage
	// ******************************************************************

	charger_regs #(
		.SECOND_VARIANT(SECOND_VARIANT)
	) u_regs (
		.clock(clock),
		.rst_b(rst_b),
		.wr_en(link_ff.wr_en),
		.wr_addr(link_ff.wr_addr),
		.wr_data(link_ff.wr_data),
		.rd_addr(link_ff.ptr),
		.source_select(source_select),
		.boost_request(boost_request),
		.source_type(source_type),
		.src(src),
		.cfg(cfg),
		.chg(chg),
		.rd_data(rd_data),
		.wd_restart(watchdog_restart),
		.charge_active(charge_active)
	);

	// ******************************************************************
	// bus conditions
	// ******************************************************************

	// pins are synchronous, so one sample of history is enough
	assign scl_rise = scl_i & ~link_ff.scl_q;
	assign scl_fall = ~scl_i & link_ff.scl_q;
	assign bus_start = scl_i & link_ff.scl_q & link_ff.sda_q & ~sda_i;
	assign bus_stop = scl_i & link_ff.scl_q & ~link_ff.sda_q & sda_i;

	// ******************************************************************
	// byte engine
	// ******************************************************************

	always_comb begin
		nxt_link = link_ff;
		nxt_link.scl_q = scl_i;
		nxt_link.sda_q = sda_i;
		nxt_link.wr_en = 1'b0;
		nxt_link.sda_o = 1'b0;
		if (bus_start) begin
			// a repeated start is handled the same as a first one
			nxt_link.state = ST_DEV;
			nxt_link.bit_cnt = 4'h0;
			nxt_link.sda_oe = 1'b0;
		end else if (bus_stop) begin
			nxt_link.state = ST_IDLE;
			nxt_link.sda_oe = 1'b0;
		end else begin
			unique case (link_ff.state)
			ST_IDLE, ST_IGNORE: begin
				nxt_link.sda_oe = 1'b0;
			end
			ST_DEV, ST_REG, ST_WDATA: begin
				if (scl_rise && link_ff.bit_cnt != 4'h8) begin
					nxt_link.shift = {link_ff.shift[6:0], sda_i};
					nxt_link.bit_cnt = link_ff.bit_cnt + 4'h1;
				end else if (scl_fall && link_ff.bit_cnt == 4'h8) begin
					// nack by leaving the line released, then wait
					nxt_link.state = ST_IGNORE;
					if (link_ff.state == ST_DEV) begin
						if (link_ff.shift[7:1] == SLAVE_ADDR) begin // R19
							nxt_link.state = ST_ACK;
							nxt_link.sda_oe = 1'b1;
							nxt_link.after_ack = link_ff.shift[0] ?
								ST_RDATA : ST_REG;
						end
					end else if (link_ff.state == ST_REG) begin
						if (link_ff.shift < `CHG_NUM_REGS) begin // R20
							nxt_link.state = ST_ACK;
							nxt_link.sda_oe = 1'b1;
							nxt_link.ptr = link_ff.shift;
							nxt_link.after_ack = ST_WDATA;
						end
					end else begin
						if (link_ff.ptr < `CHG_NUM_REGS) begin
							nxt_link.state = ST_ACK;
							nxt_link.sda_oe = 1'b1;
							nxt_link.after_ack = ST_WDATA;
							nxt_link.wr_en = 1'b1;
							nxt_link.wr_addr = link_ff.ptr;
							nxt_link.wr_data = link_ff.shift;
							nxt_link.host_mode = 1'b1; // R21
							nxt_link.ptr = link_ff.ptr + 8'h01;
						end
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					nxt_link.state = link_ff.after_ack;
					nxt_link.bit_cnt = 4'h0;
					nxt_link.shift = 8'h00;
					nxt_link.sda_oe = 1'b0;
					if (link_ff.after_ack == ST_RDATA) begin
						nxt_link.shift = rd_data; // R18
						nxt_link.sda_oe = ~rd_data[7];
					end
				end
			end
			ST_RDATA: begin
				if (scl_fall) begin
					if (link_ff.bit_cnt == 4'h7) begin
						// step the pointer now so read data settles
						nxt_link.state = ST_MACK;
						nxt_link.sda_oe = 1'b0;
						nxt_link.mack_ok = 1'b0;
						if (link_ff.ptr != 8'hff)
							nxt_link.ptr = link_ff.ptr + 8'h01;
					end else begin
						nxt_link.bit_cnt = link_ff.bit_cnt + 4'h1;
						nxt_link.shift = {link_ff.shift[6:0], 1'b0};
						nxt_link.sda_oe = ~link_ff.shift[6];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					nxt_link.mack_ok = ~sda_i;
				end else if (scl_fall) begin
					if (link_ff.mack_ok) begin
						nxt_link.state = ST_RDATA;
						nxt_link.bit_cnt = 4'h0;
						nxt_link.shift = rd_data;
						nxt_link.sda_oe = ~rd_data[7];
					end else begin
						nxt_link.state = ST_IGNORE;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b)
			link_ff <= LINK_RESET;
		else
			link_ff <= nxt_link;
	end

	// ******************************************************************
	// outputs
	// ******************************************************************

	assign sda_o = link_ff.sda_o;
	assign sda_oe = link_ff.sda_oe;
	assign host_mode = link_ff.host_mode;
	assign input_hiz_enable = src[7]; // R1
	assign input_voltage_limit = src[6:3]; // R2
	assign input_current_limit = src[2:0]; // R3
	assign boost_output_enable = cfg[`CHG_CFG_BOOST_EN]; // R10
	assign battery_charge_enable = cfg[`CHG_CFG_CHARGE_EN]; // R12
	assign min_system_voltage = cfg[3:1]; // R14
	assign boost_current_limit = cfg[0]; // R15
	assign fast_charge_current = chg[7:2]; // R17
	assign boost_cold_select = chg[1]; // R17
	assign forced_reduced_current = chg[0]; // R17

	// ******************************************************************
	// checks
	// ******************************************************************

	AST_HOST_MODE_STICKY: assert property (@(posedge clock) disable iff (!rst_b)
		host_mode |=> host_mode) // R7
		else $error("host mode dropped");
	AST_WRITE_SETS_HOST: assert property (@(posedge clock) disable iff (!rst_b)
		link_ff.wr_en |-> host_mode) // R21
		else $error("write without host mode");
	AST_BAD_ADDR_NACK: assert property (@(posedge clock) disable iff (!rst_b)
		link_ff.state == ST_REG && scl_fall && link_ff.bit_cnt == 4'h8
		&& link_ff.shift >= `CHG_NUM_REGS && !bus_start && !bus_stop
		|=> link_ff.state == ST_IGNORE && !sda_oe) // R20
		else $error("undefined register address acknowledged");
	AST_OTHER_SLAVE: assert property (@(posedge clock) disable iff (!rst_b)
		link_ff.state == ST_DEV && scl_fall && link_ff.bit_cnt == 4'h8
		&& link_ff.shift[7:1] != SLAVE_ADDR && !bus_start && !bus_stop
		|=> !sda_oe && link_ff.state == ST_IGNORE) // R19
		else $error("foreign address acknowledged");
	AST_CFG_RESET_VALUE: assert property (@(posedge clock)
		!rst_b |=> cfg == `CHG_CFG_RESET && !host_mode) // R16
		else $error("configuration reset value wrong");
	AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (!rst_b)
		sda_oe |-> !sda_o)
		else $error("data line driven high");
endmodule

// File: tb/i2c_host.sv
// two-wire bus host that drives the charger's serial port
module i2c_host (
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic pull,
	output logic got,
	output logic [7:0] got_val
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		pull = 1'b0;
		got = 1'b0;
		got_val = 8'h00;
	end
	// ****
	// bus phases, four clocks each
	// ****
	task automatic phase();
		repeat (4) @(posedge clock);
	endtask
	task automatic start();
		pull <= 1'b0;
		phase();
		scl <= 1'b1;
		phase();
		pull <= 1'b1;
		phase();
		scl <= 1'b0;
		phase();
	endtask
	task automatic stop();
		pull <= 1'b1;
		phase();
		scl <= 1'b1;
		phase();
		pull <= 1'b0;
		phase();
	endtask
	// data only moves while the clock is low
	task automatic bit_io(input logic b, output logic r);
		pull <= !b;
		phase();
		scl <= 1'b1;
		phase();
		r = sda;
		scl <= 1'b0;
		phase();
	endtask
	task automatic note(input logic [7:0] v);
		got_val <= v;
		got <= 1'b1;
		@(posedge clock);
		got <= 1'b0;
	endtask
	task automatic send(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		note({7'h00, !r});
	endtask
	// releasing on the ninth clock of the last byte ends the read
	task automatic recv(input logic last);
		logic r;
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
		note(d);
	endtask
endmodule

// File: tb/tb.sv
// self-checking bench of the charger control register bank
`define CHK(n, e, a) begin \
	checks_done++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("BAD %s exp %h got %h", n, e, a); \
	end \
end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import charger_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic source_select = 1'b0;
	logic boost_request = 1'b0;
	source_type_e source_type = SRC_SDP;
	logic scl, pull, got, sda_o, sda_oe, oe2;
	logic input_hiz_enable, boost_output_enable, battery_charge_enable;
	logic charge_active, boost_current_limit, boost_cold_select;
	logic forced_reduced_current, host_mode, watchdog_restart;
	logic [3:0] input_voltage_limit;
	logic [2:0] input_current_limit, min_system_voltage, ilim2, exp2;
	logic [5:0] fast_charge_current;
	logic [7:0] got_val, e_v;
	logic [7:0] m [0:2];
	logic [7:0] expq [$];
	int bad_count = 0;
	int checks_done = 0;
	int pulses = 0;
	int seed = 32'h50b8;
	// open drain with pull-up: released line reads high
	wire sda = !(pull || sda_oe || oe2);
	wire [7:0] out_src = {input_hiz_enable, input_voltage_limit,
		input_current_limit};
	wire [7:0] out_cfg = {2'b00, boost_output_enable, battery_charge_enable,
		min_system_voltage, boost_current_limit};
	wire [7:0] out_chg = {fast_charge_current, boost_cold_select,
		forced_reduced_current};
	always #4 clock = !clock;
	charger_control_register_bank dut_u (
		.clock(clock), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .source_select(source_select),
		.boost_request(boost_request), .source_type(source_type),
		.input_hiz_enable(input_hiz_enable),
		.input_voltage_limit(input_voltage_limit),
		.input_current_limit(input_current_limit),
		.boost_output_enable(boost_output_enable),
		.battery_charge_enable(battery_charge_enable),
		.charge_active(charge_active),
		.min_system_voltage(min_system_voltage),
		.boost_current_limit(boost_current_limit),
		.fast_charge_current(fast_charge_current),
		.boost_cold_select(boost_cold_select),
		.forced_reduced_current(forced_reduced_current),
		.host_mode(host_mode), .watchdog_restart(watchdog_restart)
	);
	// detection variant, parked at another address so it stays silent
	charger_control_register_bank #(.SLAVE_ADDR(7'h6a), .SECOND_VARIANT(1'b1))
	dut2_u (
		.clock(clock), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe(oe2), .source_select(source_select),
		.boost_request(boost_request), .source_type(source_type),
		.input_hiz_enable(), .input_voltage_limit(),
		.input_current_limit(ilim2), .boost_output_enable(),
		.battery_charge_enable(), .charge_active(),
		.min_system_voltage(), .boost_current_limit(),
		.fast_charge_current(), .boost_cold_select(),
		.forced_reduced_current(), .host_mode(), .watchdog_restart()
	);
	i2c_host host_u (
		.clock(clock), .sda(sda), .scl(scl), .pull(pull), .got(got),
		.got_val(got_val)
	);
	always @(posedge clock) begin
		if (got === 1'b1) begin
			if (expq.size() == 0) begin
				bad_count++;
				$display("BAD bus byte exp none got %h", got_val);
			end else begin
				e_v = expq.pop_front();
				`CHK("bus byte", e_v, got_val)
			end
		end
		if (rst_b && watchdog_restart === 1'b1) begin
			pulses++;
		end
	end
	// ****
	// bus and check helpers
	// ****
	task automatic defaults();
		m[0] = {5'h06, source_select ? {1'b0, boost_request, 1'b0} : 3'h7};
		m[1] = 8'h1b;
		m[2] = 8'h60;
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		defaults();
		repeat (3) @(posedge clock);
	endtask
	task automatic put(input logic [7:0] d, input logic a);
		expq.push_back({7'h00, a});
		host_u.send(d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.start();
		put(8'hd6, 1'b1);
		put(a, 1'b1);
		put(d, 1'b1);
		host_u.stop();
		if (a < 8'h03) m[a[1:0]] = (a == 8'h01) ? (d & 8'h3f) : d;
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		host_u.start();
		put(8'hd6, 1'b1);
		put(a, 1'b1);
		host_u.start();
		put(8'hd7, 1'b1);
		for (int k = 0; k < n; k++) begin
			expq.push_back(a + k < 3 ? m[a + k] : 8'h00);
			host_u.recv(k == n - 1);
		end
		host_u.stop();
	endtask
	task automatic chk_out();
		`CHK("input reg", m[0], out_src)
		`CHK("config reg", m[1], out_cfg)
		`CHK("charging", m[1][4] & !m[1][5], charge_active)
		`CHK("charge reg", m[2], out_chg)
		`CHK("drive level", 1'b0, sda_o)
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clock);
		bad_count++;
		$display("BAD run limit exp finish got hang");
		conclude();
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			source_select <= i[0];
			boost_request <= i[1];
			source_type <= source_type_e'(i[2:1]);
			do_reset();
			exp2 = (source_type == SRC_SDP) ? {1'b0, boost_request, 1'b0} :
				(source_type == SRC_DCP_CDP) ? 3'h7 :
				(source_type == SRC_DIV12) ? 3'h6 : 3'h4;
			chk_out();
			`CHK("detect external_current_limit_pin", exp2, ilim2)
			`CHK("host mode", 1'b0, host_mode)
		end
		rd(8'h00, 3);
		rd(8'h02, 2);
		$display("test defaults done");
		wr(8'h00, 8'($random(seed)));
		wr(8'h01, 8'($random(seed)) & 8'h2f);
		wr(8'h02, 8'($random(seed)));
		chk_out();
		`CHK("host mode", 1'b1, host_mode)
		rd(8'h00, 3);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {1'b0, i[3:0], i[2:0]});
			wr(8'h01, {4'h0, i[2:0], i[0]});
			chk_out();
		end
		wr(8'h01, 8'h10);
		chk_out();
		wr(8'h01, 8'h20);
		chk_out();
		$display("test fields done");
		pulses = 0;
		wr(8'h01, 8'h5b);
		repeat (2500) @(posedge clock);
		wr(8'h01, 8'h5b);
		wr(8'h01, 8'h1b);
		`CHK("restarts", 2, pulses)
		rd(8'h01, 1);
		$display("test watchdog done");
		wr(8'h02, 8'ha5);
		wr(8'h01, 8'hc0);
		defaults();
		repeat (3) @(posedge clock);
		chk_out();
		`CHK("host mode", 1'b1, host_mode)
		`CHK("restarts", 2, pulses)
		rd(8'h00, 3);
		$display("test register reset done");
		host_u.start();
		put(8'hd8, 1'b0);
		host_u.stop();
		host_u.start();
		put(8'hd6, 1'b1);
		put(8'h03, 1'b0);
		put(8'h55, 1'b0);
		host_u.stop();
		rd(8'h00, 3);
		chk_out();
		$display("test refusals done");
		repeat (4) @(posedge clock);
		`CHK("notes left", 0, expq.size())
		conclude();
	end
endmodule
